// >>> tb/host_model.sv
// Host terminal model on the serial pins
`timescale 1ns/1ns
`default_nettype none
module host_model
	import serial_ports_pkg::*;
#(
	parameter int unsigned DIV = DIV_DM
) (
	input  wire logic sys_clk_i,
	input  wire logic rxd_n_i,
	output logic      txd_n_o,
	output logic      rts_n_o
);
	initial begin
		txd_n_o = 1'b1;
		rts_n_o = 1'b0;
	end
	// ==========================================================
	// Send one frame, two stops optional
	task automatic send(input logic [7:0] d, input parity_type p, input logic two);
		logic [11:0] f;
		int i;
		f = (p == PAR_NONE) ? {3'b111, d, 1'b0} : {2'b11, (p == PAR_ODD) ^ (^d), d, 1'b0};
		for (i = 0; i < 10 + int'(two) + int'(p != PAR_NONE); i++) begin
			@(posedge sys_clk_i);
			txd_n_o <= f[i];
			repeat (DIV - 1) @(posedge sys_clk_i);
		end
	endtask
	// Sample n bits mid cell, start bit first
	task automatic recv(input int n, output logic [11:0] v, output logic ok);
		int t;
		v = 12'h000;
		for (t = 0; t < 3000 && rxd_n_i; t++) @(posedge sys_clk_i);
		ok = !rxd_n_i;
		repeat (DIV / 2) @(posedge sys_clk_i);
		for (t = 0; t < n; t++) begin
			v[t] = rxd_n_i;
			repeat (DIV) @(posedge sys_clk_i);
		end
	endtask
	task automatic set_rts(input logic v);
		@(posedge sys_clk_i);
		rts_n_o <= v;
	endtask
endmodule // host_model
`default_nettype wire

// >>> tb/serial_port_sva.sv
// Checker for the device side serial port
`timescale 1ns/1ns
`default_nettype none
module serial_port_sva
	import serial_ports_pkg::*;
(
	// Clock, reset and configuration
	input wire logic        sys_clk_i, sys_rst_i, autobaud_en_i, data_mover_i, low_power_i,
	input wire flow_type    flow_mode_i,
	// User and pin side
	input wire logic        tx_valid_i, tx_ready_o, rx_valid_o, rx_ready_i, rts_n_i,
	input wire logic        rxd_n_o, cts_n_o, rate_locked_o,
	input wire logic [7:0]  rx_data_o,
	input wire logic [15:0] rate_div_o
);
	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (sys_rst_i);
	// ==========================================================
	// Frame steps
	sequence take_s;
		tx_valid_i && tx_ready_o;
	endsequence
	sequence start_s;
		!rxd_n_o [*8];
	endsequence
	// ==========================================================
	// Properties
	lp_cts_a: assert property (low_power_i |-> cts_n_o)
		else $error("cts active in low power");
	lp_ready_a: assert property (low_power_i |-> !tx_ready_o)
		else $error("send accepted in low power");
	start_bit_a: assert property (take_s |=> ##1 start_s)
		else $error("start bit missing");
	one_frame_a: assert property (take_s |=> !tx_ready_o [*8])
		else $error("second frame accepted");
	unlock_hold_a: assert property (autobaud_en_i && !rate_locked_o |-> !tx_ready_o)
		else $error("send before rate lock");
	rts_block_a: assert property (flow_mode_i == FLOW_HW && rts_n_i && $past(rts_n_i)
		&& $past(rts_n_i, 2) && $past(rts_n_i, 3) |-> !tx_ready_o) else $error("rts ignored");
	dm_rate_a: assert property (!autobaud_en_i && data_mover_i |-> rate_div_o == 16'(DIV_DM))
		else $error("mover rate wrong");
	def_rate_a: assert property (!autobaud_en_i && !data_mover_i |-> rate_div_o == 16'(DIV_DEF))
		else $error("default rate wrong");
	rx_hold_a: assert property (rx_valid_o && !rx_ready_i |=> rx_valid_o && $stable(rx_data_o))
		else $error("rx byte lost");
endmodule // serial_port_sva
bind serial_port serial_port_sva chk (.sys_clk_i, .sys_rst_i, .autobaud_en_i, .data_mover_i,
	.low_power_i, .flow_mode_i, .tx_valid_i, .tx_ready_o, .rx_valid_o, .rx_ready_i, .rts_n_i,
	.rxd_n_o, .cts_n_o, .rate_locked_o, .rx_data_o, .rate_div_o);
`default_nettype wire

// >>> tb/test_serial_port.sv
// Self-checking bench for the primary serial port
`timescale 1ns/1ns
`default_nettype none
module test_serial_port;
	import serial_ports_pkg::*;
	logic       sys_clk_i = 1'b0, sys_rst_i = 1'b1, two_stop_i = STOP2_RST;
	logic       autobaud_en_i = AUTOBAUD_RST, data_mover_i = 1'b0, low_power_i = 1'b0;
	logic       dsr_active_i = 1'b0, dcd_active_i = 1'b0, ring_active_i = 1'b0, dtr_n_i = 1'b1;
	logic       tx_valid_i = 1'b0, rx_ready_i = 1'b0, tx_ready_o, rx_valid_o, rxd_n_o, cts_n_o;
	logic       rate_locked_o, parity_err_o, dsr_n_o, dcd_n_o, ri_n_o, dtr_seen_o, txd_n, rts_n;
	logic       frame_err_o;
	logic [7:0] tx_data_i = 8'h00, rx_data_o;
	logic [15:0] rate_div_o;
	flow_type   flow_mode_i = FLOW_RST;
	parity_type parity_mode_i = PARITY_RST;
	int         n_errors = 0, cmp_count = 0;
	always #5 sys_clk_i = ~sys_clk_i;
	serial_port uut (.sys_clk_i, .sys_rst_i, .flow_mode_i, .parity_mode_i, .two_stop_i,
		.autobaud_en_i, .data_mover_i, .low_power_i, .dsr_active_i, .dcd_active_i,
		.ring_active_i, .rate_locked_o, .rate_div_o, .parity_err_o, .frame_err_o, .tx_data_i,
		.tx_valid_i, .tx_ready_o, .rx_data_o, .rx_valid_o, .rx_ready_i, .txd_n_i(txd_n), .rxd_n_o,
		.rts_n_i(rts_n), .cts_n_o, .dtr_n_i, .dsr_n_o, .dcd_n_o, .ri_n_o, .dtr_seen_o);
	host_model host (.sys_clk_i, .rxd_n_i(rxd_n_o), .txd_n_o(txd_n), .rts_n_o(rts_n));
	// ==========================================================
	// Shared tasks
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			n_errors++;
			$display("BAD t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	task automatic wait_hi(ref logic s);
		int t;
		for (t = 0; t < 3000 && s !== 1'b1; t++) @(negedge sys_clk_i);
		if (s !== 1'b1) begin
			n_errors++;
			conclude();
		end
	endtask
	task automatic pop();
		@(posedge sys_clk_i);
		rx_ready_i <= 1'b1;
		@(posedge sys_clk_i);
		rx_ready_i <= 1'b0;
	endtask
	task automatic put_tx(input logic [7:0] d);
		@(posedge sys_clk_i);
		tx_data_i <= d;
		tx_valid_i <= 1'b1;
		wait_hi(tx_ready_o);
		@(posedge sys_clk_i);
		tx_valid_i <= 1'b0;
	endtask
	// ==========================================================
	// Scenarios
	task automatic t_lock();
		host.send(8'h55, PAR_NONE, 1'b0);
		wait_hi(rate_locked_o);
		check(rate_div_o, 16'(DIV_DM));
		repeat (400) @(negedge sys_clk_i);
		if (rx_valid_o) pop();
		$display("lock done");
	endtask
	task automatic t_frames();
		logic [11:0] v;
		logic ok;
		int p, s, n;
		for (p = 0; p < 3; p++) for (s = 0; s < 2; s++) begin
			@(posedge sys_clk_i);
			parity_mode_i <= parity_type'(p);
			two_stop_i <= s[0];
			put_tx(8'hA4 + 8'(p));
			n = 10 + s + int'(p != 0);
			host.recv(n, v, ok);
			check({ok, v[8:0]}, {1'b1, 8'hA4 + 8'(p), 1'b0});
			if (p != 0) check(v[9], (p == 1) ^ (^(8'hA4 + 8'(p))));
			check({v[n-1], v[n-1-s]}, 2'b11);
		end
		$display("frames done");
	endtask
	task automatic t_rx(input logic [7:0] d, input parity_type hp, input logic perr);
		host.send(d, hp, 1'b0);
		wait_hi(rx_valid_o);
		check(rx_data_o, d);
		check(parity_err_o, perr);
		check(frame_err_o, 1'b0);
		pop();
		$display("rx done");
	endtask
	task automatic t_flow();
		host.set_rts(1'b1);
		repeat (5) @(negedge sys_clk_i);
		check({tx_ready_o, cts_n_o}, 2'b00);
		host.set_rts(1'b0);
		low_power_i <= 1'b1;
		repeat (2) @(negedge sys_clk_i);
		check({tx_ready_o, cts_n_o}, 2'b01);
		low_power_i <= 1'b0;
		flow_mode_i <= FLOW_SW;
		host.send(XOFF_CHAR, PAR_NONE, 1'b0);
		repeat (4) @(negedge sys_clk_i);
		check({tx_ready_o, rx_valid_o}, 2'b00);
		host.send(XON_CHAR, PAR_NONE, 1'b0);
		repeat (4) @(negedge sys_clk_i);
		check({tx_ready_o, rx_valid_o}, 2'b10);
		flow_mode_i <= FLOW_NONE;
		$display("flow done");
	endtask
	task automatic t_modem_rates();
		@(posedge sys_clk_i);
		{dsr_active_i, dcd_active_i, ring_active_i, dtr_n_i} <= 4'hE;
		autobaud_en_i <= 1'b0;
		data_mover_i <= 1'b1;
		repeat (4) @(negedge sys_clk_i);
		check({dsr_n_o, dcd_n_o, ri_n_o, dtr_seen_o}, 4'h1);
		check(rate_div_o, 16'(DIV_DM));
		data_mover_i <= 1'b0;
		@(negedge sys_clk_i);
		check(rate_div_o, 16'(DIV_DEF));
		$display("modem done");
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge sys_clk_i);
		sys_rst_i <= 1'b0;
		@(negedge sys_clk_i);
		check({rxd_n_o, rate_locked_o, tx_ready_o}, 3'b100);
		t_lock();
		t_frames();
		parity_mode_i <= PAR_EVEN;
		t_rx(8'h3C, PAR_EVEN, 1'b0);
		t_rx(8'h81, PAR_ODD, 1'b1);
		parity_mode_i <= PAR_NONE;
		t_flow();
		t_modem_rates();
		conclude();
	end
endmodule // test_serial_port
`default_nettype wire

// >>> verilog/serial_port.sv
// One asynchronous serial port seen from the device side
`timescale 1ns/1ns
`default_nettype none
module serial_port
	import serial_ports_pkg::*;
#(
	parameter bit          FULL_PORT = 1'b1,
	parameter int unsigned DEPTH     = FIFO_DEPTH
) (
	// Clock and reset
	input  wire logic       sys_clk_i,
	input  wire logic       sys_rst_i,
	// Configuration
	input  wire flow_type   flow_mode_i,
	input  wire parity_type parity_mode_i,
	input  wire logic       two_stop_i,
	input  wire logic       autobaud_en_i,
	input  wire logic       data_mover_i,
	input  wire logic       low_power_i,
	input  wire logic       dsr_active_i,
	input  wire logic       dcd_active_i,
	input  wire logic       ring_active_i,
	// Status
	output logic            rate_locked_o,
	output logic [15:0]     rate_div_o,
	output logic            parity_err_o,
	output logic            frame_err_o,
	// Transmit user side
	input  wire logic [7:0] tx_data_i,
	input  wire logic       tx_valid_i,
	output logic            tx_ready_o,
	// Receive user side
	output logic [7:0]      rx_data_o,
	output logic            rx_valid_o,
	input  wire logic       rx_ready_i,
	// Serial pins, all active low levels except dtr_seen_o
	input  wire logic       txd_n_i,
	output logic            rxd_n_o,
	input  wire logic       rts_n_i,
	output logic            cts_n_o,
	input  wire logic       dtr_n_i,
	output logic            dsr_n_o,
	output logic            dcd_n_o,
	output logic            ri_n_o,
	output logic            dtr_seen_o
);
	// ==========================================================
	// Pin synchronisers
	logic [1:0] txd_sync_reg;
	logic [1:0] rts_sync_reg;
	logic [1:0] dtr_sync_reg;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			txd_sync_reg <= 2'h3;
			rts_sync_reg <= 2'h3;
			dtr_sync_reg <= 2'h3;
		end else begin
			txd_sync_reg <= {txd_sync_reg[0], txd_n_i};
			rts_sync_reg <= {rts_sync_reg[0], rts_n_i};
			dtr_sync_reg <= {dtr_sync_reg[0], dtr_n_i};
		end
	end
	wire line_in   = txd_sync_reg[1];
	wire host_rts  = !rts_sync_reg[1];
	// ==========================================================
	// Modem status lines, primary only
	assign dsr_n_o    = FULL_PORT ? !dsr_active_i : 1'b1;
	assign dcd_n_o    = FULL_PORT ? !dcd_active_i : 1'b1;
	assign ri_n_o     = FULL_PORT ? !ring_active_i : 1'b1;
	assign dtr_seen_o = FULL_PORT ? !dtr_sync_reg[1] : 1'b0;
	// ==========================================================
	// Bit rate selection
	logic [15:0] auto_div_reg;
	logic        locked_reg;
	wire  [15:0] fixed_div = data_mover_i ? 16'(DIV_DM) : 16'(DIV_DEF);
	wire  [15:0] bit_div   = (autobaud_en_i && locked_reg) ? auto_div_reg : fixed_div;
	wire         rx_enable = !low_power_i && (!autobaud_en_i || locked_reg);
	assign rate_locked_o = locked_reg;
	assign rate_div_o    = bit_div;
	function automatic logic parity_of(input logic [7:0] d, input parity_type p);
		parity_of = (p == PAR_ODD) ? !(^d) : (^d);
	endfunction
	// ==========================================================
	// Autobaud measurement of first start bit
	logic [15:0] meas_reg;
	logic        meas_run_reg;
	logic        line_prev_reg;
	wire  [15:0] meas_pick = (meas_reg < 16'(DIV_DM + DIV_DM / 2)) ? 16'(DIV_DM) :
	                         (meas_reg < 16'((DIV_STD + DIV_DEF) / 2)) ? 16'(DIV_STD) :
	                         16'(DIV_DEF);
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			meas_reg      <= '0;
			meas_run_reg  <= 1'b0;
			locked_reg    <= 1'b0;
			auto_div_reg  <= 16'(DIV_DEF);
			line_prev_reg <= 1'b1;
		end else begin
			line_prev_reg <= line_in;
			if (!autobaud_en_i) begin
				locked_reg   <= 1'b0;
				meas_run_reg <= 1'b0;
			end else if (!locked_reg && !low_power_i) begin
				if (line_prev_reg && !line_in) begin
					meas_run_reg <= 1'b1;
					meas_reg     <= 16'h0001;
				end else if (meas_run_reg && !line_in && meas_reg != 16'hFFFF) begin
					meas_reg <= meas_reg + 16'h0001;
				end else if (meas_run_reg && line_in) begin
					meas_run_reg <= 1'b0;
					auto_div_reg <= meas_pick;
					locked_reg   <= 1'b1;
				end
			end
		end
	end
	// ==========================================================
	// Receiver
	typedef enum logic [2:0] {
		RX_IDLE   = 3'h0,
		RX_START  = 3'h1,
		RX_DATA   = 3'h2,
		RX_PARITY = 3'h3,
		RX_STOP   = 3'h4
	} rx_state_type;
	rx_state_type rx_state_reg;
	logic [15:0]  rx_cnt_reg;
	logic [2:0]   rx_bit_reg;
	logic [7:0]   rx_shift_reg;
	logic         rx_push_reg;
	logic         perr_reg;
	logic         ferr_reg;
	logic         xoff_reg;
	wire          rx_tick = rx_cnt_reg == '0;
	wire          fifo_in_ready;
	wire          is_ctrl = (flow_mode_i == FLOW_SW) &&
	                        (rx_shift_reg == XON_CHAR || rx_shift_reg == XOFF_CHAR);
	assign parity_err_o = perr_reg;
	assign frame_err_o  = ferr_reg;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rx_state_reg <= RX_IDLE;
			rx_cnt_reg   <= '0;
			rx_bit_reg   <= '0;
			rx_shift_reg <= '0;
			rx_push_reg  <= 1'b0;
			perr_reg     <= 1'b0;
			ferr_reg     <= 1'b0;
			xoff_reg     <= 1'b0;
		end else begin
			rx_push_reg <= 1'b0;
			if (rx_cnt_reg != '0) rx_cnt_reg <= rx_cnt_reg - 16'h0001;
			if (flow_mode_i != FLOW_SW) xoff_reg <= 1'b0;
			unique case (rx_state_reg)
				RX_IDLE: begin
					if (rx_enable && !line_in) begin
						rx_state_reg <= RX_START;
						rx_cnt_reg   <= {1'b0, bit_div[15:1]};
					end
				end
				RX_START: begin
					if (rx_tick) begin
						rx_state_reg <= line_in ? RX_IDLE : RX_DATA;
						rx_cnt_reg   <= bit_div - 16'h0001;
						rx_bit_reg   <= '0;
					end
				end
				RX_DATA: begin
					if (rx_tick) begin
						rx_shift_reg <= {!line_in ? 1'b0 : 1'b1, rx_shift_reg[7:1]};
						rx_cnt_reg   <= bit_div - 16'h0001;
						rx_bit_reg   <= rx_bit_reg + 3'h1;
						if (rx_bit_reg == 3'h7) begin
							rx_state_reg <= (parity_mode_i == PAR_NONE) ? RX_STOP : RX_PARITY;
						end
					end
				end
				RX_PARITY: begin
					if (rx_tick) begin
						perr_reg     <= line_in != parity_of(rx_shift_reg, parity_mode_i);
						rx_cnt_reg   <= bit_div - 16'h0001;
						rx_state_reg <= RX_STOP;
					end
				end
				RX_STOP: begin
					if (rx_tick) begin
						ferr_reg     <= !line_in;
						rx_state_reg <= RX_IDLE;
						if (line_in && is_ctrl) begin
							xoff_reg <= rx_shift_reg == XOFF_CHAR;
						end else if (line_in) begin
							rx_push_reg <= 1'b1;
						end
					end
				end
				default: rx_state_reg <= RX_IDLE;
			endcase
		end
	end
	word_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rx_fifo (
		.sys_clk_i   (sys_clk_i),
		.sys_rst_i   (sys_rst_i),
		.in_data_i   (rx_shift_reg),
		.in_valid_i  (rx_push_reg),
		.in_ready_o  (fifo_in_ready),
		.out_data_o  (rx_data_o),
		.out_valid_o (rx_valid_o),
		.out_ready_i (rx_ready_i)
	);
	// Tell the host to stop while asleep, or with hardware flow while space is short
	wire rx_space_ok = fifo_in_ready && !low_power_i;
	assign cts_n_o = (flow_mode_i == FLOW_HW) ? !rx_space_ok : low_power_i;
	// ==========================================================
	// Transmitter
	typedef enum logic [1:0] {
		TX_IDLE  = 2'h0,
		TX_SHIFT = 2'h1
	} tx_state_type;
	tx_state_type tx_state_reg;
	logic [11:0]  tx_frame_reg;
	logic [3:0]   tx_left_reg;
	logic [15:0]  tx_cnt_reg;
	logic         rxd_reg;
	wire          host_go = (flow_mode_i == FLOW_HW) ? host_rts :
	                        (flow_mode_i == FLOW_SW) ? !xoff_reg : 1'b1;
	wire          tx_can  = rx_enable && host_go;
	wire          tx_par  = parity_of(tx_data_i, parity_mode_i);
	wire          has_par = parity_mode_i != PAR_NONE;
	wire [3:0]    tx_bits = 4'hA + {3'h0, has_par} + {3'h0, two_stop_i};
	assign tx_ready_o = (tx_state_reg == TX_IDLE) && tx_can;
	assign rxd_n_o    = rxd_reg;
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_state_reg <= TX_IDLE;
			tx_frame_reg <= '1;
			tx_left_reg  <= '0;
			tx_cnt_reg   <= '0;
			rxd_reg      <= 1'b1;
		end else begin
			unique case (tx_state_reg)
				TX_IDLE: begin
					rxd_reg <= 1'b1;
					if (tx_valid_i && tx_can) begin
						// Start low, data LSB first, parity, stops high
						tx_frame_reg <= has_par ? {2'h3, tx_par, tx_data_i, 1'b0}
						                        : {3'h7, tx_data_i, 1'b0};
						tx_left_reg  <= tx_bits;
						tx_cnt_reg   <= '0;
						tx_state_reg <= TX_SHIFT;
					end
				end
				TX_SHIFT: begin
					if (tx_cnt_reg == '0) begin
						// Last stop bit has stood its full time before idle
						if (tx_left_reg == 4'h0) begin
							tx_state_reg <= TX_IDLE;
						end else begin
							rxd_reg      <= tx_frame_reg[0];
							tx_frame_reg <= {1'b1, tx_frame_reg[11:1]};
							tx_cnt_reg   <= bit_div - 16'h0001;
							tx_left_reg  <= tx_left_reg - 4'h1;
						end
					end else begin
						tx_cnt_reg <= tx_cnt_reg - 16'h0001;
					end
				end
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end
endmodule // serial_port
`default_nettype wire

// >>> verilog/serial_ports_pkg.sv
// Package of constants for the host serial ports block
// Notes on behaviour
// - Primary port has eight signals: data, flow control and modem status lines.
// - Secondary port has four signals: transmit, receive and two flow lines.
// - All port signals are active low logic levels; transceivers are external.
// - Device is DCE, host is DTE; this fixes every line direction.
// - Primary supports up to 4 Mbps on data-mover path, 230 kbps standard.
// - Flow control selectable: hardware, software characters, or none.
// - Parity setting and stop bit count are configurable.
// - Reset default: 8 data, 1 stop, no parity, hardware flow, autobaud on.
// - Secondary port serves general serial traffic like the primary.
// - In low power mode ports disabled; clear-to-send held high with hardware flow.
package serial_ports_pkg;
	// ==========================================================
	// Clock and rates
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned RATE_DM_BPS     = 4_000_000;
	localparam int unsigned RATE_STD_BPS    = 230_400;
	localparam int unsigned RATE_DEF_BPS    = 115_200;
	localparam int unsigned DIV_DM          = CLK_HZ / RATE_DM_BPS;
	localparam int unsigned DIV_STD         = CLK_HZ / RATE_STD_BPS;
	localparam int unsigned DIV_DEF         = CLK_HZ / RATE_DEF_BPS;
	localparam int unsigned DIV_W           = 16;
	// ==========================================================
	// Flow control modes
	typedef enum logic [1:0] {
		FLOW_NONE = 2'h0,
		FLOW_HW   = 2'h1,
		FLOW_SW   = 2'h2
	} flow_type;
	// Parity modes
	typedef enum logic [1:0] {
		PAR_NONE = 2'h0,
		PAR_ODD  = 2'h1,
		PAR_EVEN = 2'h2
	} parity_type;
	// ==========================================================
	// Reset values
	localparam flow_type   FLOW_RST     = FLOW_HW;
	localparam parity_type PARITY_RST   = PAR_NONE;
	localparam logic       STOP2_RST    = 1'b0;
	localparam logic       AUTOBAUD_RST = 1'b1;
	// Software flow characters
	localparam logic [7:0] XON_CHAR     = 8'h11;
	localparam logic [7:0] XOFF_CHAR    = 8'h13;
	localparam int unsigned FIFO_DEPTH  = 32;
endpackage

// >>> verilog/word_fifo.sv
// Synchronous FIFO with valid and ready on both sides
`timescale 1ns/1ns
`default_nettype none
module word_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	// Clock and reset
	input  wire logic             sys_clk_i,
	input  wire logic             sys_rst_i,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data_i,
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	// Drain side
	output logic      [WIDTH-1:0] out_data_o,
	output logic                  out_valid_o,
	input  wire logic             out_ready_i
);
	localparam int unsigned AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0]    wr_ptr_reg;
	logic [AW-1:0]    rd_ptr_reg;
	logic [AW:0]      count_reg;
	wire              push = in_valid_i && in_ready_o;
	wire              pop  = out_valid_o && out_ready_i;
	assign in_ready_o  = count_reg != (AW+1)'(DEPTH);
	assign out_valid_o = count_reg != '0;
	assign out_data_o  = mem[rd_ptr_reg];
	always_ff @(posedge sys_clk_i) begin
		if (push) begin
			mem[wr_ptr_reg] <= in_data_i;
		end
	end
	always_ff @(posedge sys_clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg  <= '0;
		end else begin
			if (push) wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop) rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
			if (push && !pop) count_reg <= count_reg + 1'b1;
			else if (pop && !push) count_reg <= count_reg - 1'b1;
		end
	end
endmodule // word_fifo
`default_nettype wire
